// File: src/link_slave.sv
// clock-slave end of the handshaked half-duplex serial link, with a wishbone register port
// How it works
// RL1: both ends drive lines open-drain only; the slave drives data high when the open-drain bit is clear
// RL2: open-drain enable bit gates data drive
// RL3: clock idles low, launch rise, sample fall
// RL4: master shifts eight bits, at most 125kHz; the bench master clocks with a 320 ns period
// RL5: msb first; capture each bit on fall
// RL6: transmitter releases data high after last bit
// RL7: slave restores data high after sending
// RL8: slave-select pin is an output, never input; the code keeps it an input until the clock line is seen low
// RL9: slave clamps data; master toggles clock
// RL10: full handshake precedes every byte
// RL11: master loads all ones before receiving
// RL12: master clocks every byte in both directions
// RL13: one done flag, bit 7, both directions
// RL14: writing zero to done flag clears it
// RL15: master clears flag by status then data; the master model clears it at once
// RL16: readback mismatch flags line contention
// RL17: pins inputs until clock line seen low
// RL18: master picks direction; sender announces length
// RL19: first master byte is a control byte
// RL20: listen: count then that many bytes in
// RL21: talk control byte has value 2
// RL22: talk: slave sends count then data
// RL23: clock released, data clamped, clock low
// RL24: on clock low load, enable, unclamp
// RL25: slave disables its port after each byte
// RL26: listen control byte has value 1
// RL27: both lines pulled up externally
//
// The Wishbone register port and the placing of the registers were decided locally.
`timescale 1ns/1ns
module link_slave
  import link_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // wishbone slave
  input wire wb_req_t wbReq,
  output logic wbAck,
  output logic [31:0] wbDatOut,
  // serial clock line, read only
  input wire logic sckIn,
  // shared data line
  input wire logic sdaIn,
  output od_pin_t sdaPin,
  // unused slave-select pin
  output od_pin_t ssPin
);
  function automatic logic hitOfs(input logic [ADR_W-1:0] adr, input logic [ADR_W-1:0] ofs);
    hitOfs = (adr == ofs);
  endfunction

  link_state_t state_r, state_nxt;
  frame_phase_t phase_r;
  logic sckMeta_r, sckSync_r, sckPrev_r;
  logic sdaMeta_r, sdaSync_r;
  logic sckRise, sckFall;
  logic ack_r;
  logic [31:0] datOut_r;
  logic busWr, busRd;
  logic wiredOr_r, arm_r, done_r, err_r, talk_r;
  logic [7:0] txByte_r, rxByte_r, shift_r, remain_r;
  logic [2:0] bitCnt_r;
  logic txMode;
  od_pin_t sda_r, ss_r;

  // synchronisers for the pins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sckMeta_r <= 1'b1; // [RL27]
      sckSync_r <= 1'b1;
      sckPrev_r <= 1'b1;
      sdaMeta_r <= 1'b1;
      sdaSync_r <= 1'b1;
    end else begin
      sckMeta_r <= sckIn;
      sckSync_r <= sckMeta_r;
      sckPrev_r <= sckSync_r;
      sdaMeta_r <= sdaIn;
      sdaSync_r <= sdaMeta_r;
    end
  end

  assign sckRise = sckSync_r & ~sckPrev_r;
  assign sckFall = ~sckSync_r & sckPrev_r;
  assign txMode = talk_r & (phase_r != PH_CMD);

  // wishbone: one wait state, ack for a single cycle
  assign busWr = wbReq.cyc & wbReq.stb & wbReq.we & ~ack_r & wbReq.sel[0];
  assign busRd = wbReq.cyc & wbReq.stb & ~wbReq.we & ~ack_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= wbReq.cyc & wbReq.stb & ~ack_r;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      datOut_r <= WORD_ZERO;
    end else if (busRd) begin
      datOut_r <= WORD_ZERO;
      if (hitOfs(wbReq.adr, OFS_CTRL)) begin
        datOut_r[BIT_DONE] <= done_r;
        datOut_r[BIT_WOR] <= wiredOr_r;
        datOut_r[BIT_ARM] <= arm_r;
      end else if (hitOfs(wbReq.adr, OFS_DATA)) begin
        datOut_r[7:0] <= rxByte_r;
      end else if (hitOfs(wbReq.adr, OFS_STAT)) begin
        datOut_r[BIT_ERR] <= err_r;
        datOut_r[BIT_TALK] <= talk_r;
        datOut_r[PH_LSB +: 3] <= phase_r;
        datOut_r[CNT_LSB +: 8] <= remain_r;
      end
    end
  end

  assign wbAck = ack_r;
  assign wbDatOut = datOut_r;

  // control register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wiredOr_r <= 1'b0;
    end else if (busWr && hitOfs(wbReq.adr, OFS_CTRL)) begin
      wiredOr_r <= wbReq.dat[BIT_WOR]; // [RL2]
    end
  end

  // arm asks for the next byte's handshake; software setting it wins over the clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      arm_r <= 1'b0;
    end else if (busWr && hitOfs(wbReq.adr, OFS_CTRL) && wbReq.dat[BIT_ARM]) begin
      arm_r <= 1'b1;
    end else if (state_r == ST_LOAD) begin
      arm_r <= 1'b0;
    end
  end

  // done flag: set by a completed byte, cleared by writing zero, set wins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      done_r <= 1'b0;
    end else if (state_r == ST_DONE) begin
      done_r <= 1'b1; // [RL13]
    end else if (busWr && hitOfs(wbReq.adr, OFS_CTRL) && !wbReq.dat[BIT_DONE]) begin
      done_r <= 1'b0; // [RL14]
    end
  end

  // readback check after sending; cleared by writing zero to its status bit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      err_r <= 1'b0;
    end else if (state_r == ST_DONE && txMode && shift_r != txByte_r) begin
      err_r <= 1'b1; // [RL16]
    end else if (busWr && hitOfs(wbReq.adr, OFS_STAT) && !wbReq.dat[BIT_ERR]) begin
      err_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      txByte_r <= BYTE_RST;
    end else if (busWr && hitOfs(wbReq.adr, OFS_DATA)) begin
      txByte_r <= wbReq.dat[7:0];
    end
  end

  // handshake and byte sequencer
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_INIT: begin
        if (!sckSync_r) begin
          state_nxt = ST_IDLE; // [RL17]
        end
      end
      ST_IDLE: begin
        if (arm_r && sckSync_r) begin
          state_nxt = ST_CLAMP; // [RL10] [RL23]
        end
      end
      ST_CLAMP: begin
        if (!sckSync_r) begin
          state_nxt = ST_LOAD; // [RL24]
        end
      end
      ST_LOAD: begin
        state_nxt = ST_SHIFT;
      end
      ST_SHIFT: begin
        if (sckFall && bitCnt_r == BIT_LAST) begin
          state_nxt = ST_DONE; // [RL5]
        end
      end
      ST_DONE: begin
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_INIT;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_INIT;
    end else begin
      state_r <= state_nxt;
    end
  end

  // shift register: load on handshake, sample on the falling clock edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shift_r <= BYTE_ONES;
      bitCnt_r <= BIT_FIRST;
    end else if (state_r == ST_LOAD) begin
      shift_r <= txMode ? txByte_r : BYTE_ONES; // [RL24]
      bitCnt_r <= BIT_FIRST;
    end else if (state_r == ST_SHIFT && sckFall) begin
      shift_r <= {shift_r[6:0], sdaSync_r}; // [RL3] [RL5]
      bitCnt_r <= bitCnt_r + BIT_STEP;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rxByte_r <= BYTE_RST;
    end else if (state_r == ST_DONE) begin
      rxByte_r <= shift_r;
    end
  end

  // data pin: clamp during handshake, drive bits on rising edges, release otherwise
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sda_r <= '{level: 1'b1, oeN: 1'b1};
    end else begin
      case (state_r)
        ST_CLAMP: begin
          sda_r <= '{level: 1'b0, oeN: 1'b0}; // [RL9] [RL23]
        end
        ST_SHIFT: begin
          if (sckRise && txMode) begin
            sda_r.level <= shift_r[7]; // [RL3] [RL5]
            sda_r.oeN <= shift_r[7] & wiredOr_r; // [RL1] [RL2]
          end
        end
        default: begin
          sda_r <= '{level: 1'b1, oeN: 1'b1}; // [RL6] [RL7] [RL25] [RL17]
        end
      endcase
    end
  end

  // slave-select pin left as input during start-up, then an output held high
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ss_r <= '{level: 1'b1, oeN: 1'b1};
    end else if (state_r != ST_INIT) begin
      ss_r <= '{level: 1'b1, oeN: 1'b0}; // [RL8]
    end
  end

  assign sdaPin = sda_r;
  assign ssPin = ss_r;

  // frame tracking: control byte, count, then the data stream
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_r <= PH_CMD;
      talk_r <= 1'b0;
      remain_r <= BYTE_RST;
    end else if (state_r == ST_DONE) begin
      case (phase_r)
        PH_CMD: begin
          if (shift_r == CMD_LISTEN) begin
            phase_r <= PH_COUNT; // [RL19] [RL26]
            talk_r <= 1'b0; // [RL20]
          end else if (shift_r == CMD_TALK) begin
            phase_r <= PH_COUNT; // [RL21]
            talk_r <= 1'b1; // [RL22]
          end
        end
        PH_COUNT: begin
          remain_r <= shift_r; // [RL18]
          if (shift_r == BYTE_RST) begin
            phase_r <= PH_CMD;
            talk_r <= 1'b0;
          end else begin
            phase_r <= PH_DATA;
          end
        end
        PH_DATA: begin
          remain_r <= remain_r - CNT_STEP;
          if (remain_r == CNT_STEP) begin
            phase_r <= PH_CMD; // [RL20] [RL22]
            talk_r <= 1'b0;
          end
        end
        default: begin
          phase_r <= PH_CMD;
        end
      endcase
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence lastFall;
    state_r == ST_SHIFT && sckFall && bitCnt_r == BIT_LAST;
  endsequence

  sequence byteClosed;
    state_r == ST_DONE ##1 (done_r && sda_r.oeN && state_r == ST_IDLE);
  endsequence

  a_byte_complete: assert property (lastFall |=> byteClosed) // [RL13]
    else $error("byte end did not set done and release data");
  a_release_after: assert property (state_r == ST_DONE |=> sda_r.oeN && sda_r.level) // [RL7]
    else $error("data line not released after byte");
  a_init_inputs: assert property (state_r == ST_INIT |=> sda_r.oeN && ss_r.oeN) // [RL17]
    else $error("link pin driven before clock seen low");
  a_clamp_before: assert property ($rose(state_r == ST_LOAD) |-> $past(state_r) == ST_CLAMP) // [RL10]
    else $error("byte loaded without handshake");
  a_clamp_drive: assert property (state_r == ST_CLAMP |=> !sda_r.oeN && !sda_r.level) // [RL23]
    else $error("data line not clamped in handshake");
  a_open_drain: assert property (wiredOr_r && !sda_r.oeN |-> !sda_r.level) // [RL1]
    else $error("data line driven high in open-drain mode");
  a_msb_first: assert property (state_r == ST_SHIFT && sckRise && txMode && bitCnt_r == BIT_FIRST
      |=> sda_r.level == $past(shift_r[7]) && sda_r.level == $past(txByte_r[7])) // [RL5]
    else $error("first bit out is not the msb");
  a_done_clear: assert property (busWr && hitOfs(wbReq.adr, OFS_CTRL) && !wbReq.dat[BIT_DONE]
      && state_r != ST_DONE |=> !done_r) // [RL14]
    else $error("writing zero did not clear done flag");
  a_talk_decode: assert property (state_r == ST_DONE && phase_r == PH_CMD && shift_r == CMD_TALK
      |=> talk_r && phase_r == PH_COUNT) // [RL21]
    else $error("talk control byte not decoded");
  a_mismatch_flag: assert property (state_r == ST_DONE && txMode && shift_r != txByte_r
      |=> err_r) // [RL16]
    else $error("readback mismatch not flagged");
  a_ss_output: assert property (state_r != ST_INIT |=> !ss_r.oeN && ss_r.level) // [RL8]
    else $error("slave-select pin not driven as output");
  a_bus_ack: assert property (wbReq.cyc && wbReq.stb && !ack_r |=> ack_r ##1 !ack_r)
    else $error("wishbone ack not a single cycle");
endmodule

// File: src/link_pkg.sv
// constants, carriers and state types for the handshaked half-duplex serial link slave
package link_pkg;
  localparam int ADR_W = 4;
  // register byte offsets
  localparam logic [ADR_W-1:0] OFS_CTRL = 4'h0;
  localparam logic [ADR_W-1:0] OFS_DATA = 4'h4;
  localparam logic [ADR_W-1:0] OFS_STAT = 4'h8;
  // control register fields
  localparam int BIT_DONE = 7;
  localparam int BIT_WOR = 3;
  localparam int BIT_ARM = 2;
  // status register fields
  localparam int BIT_ERR = 0;
  localparam int BIT_TALK = 1;
  localparam int PH_LSB = 2;
  localparam int CNT_LSB = 8;
  // frame control bytes
  localparam logic [7:0] CMD_LISTEN = 8'h01;
  localparam logic [7:0] CMD_TALK = 8'h02;
  // reset values, bit and count limits and steps
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [7:0] BYTE_ONES = 8'hff;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [2:0] BIT_STEP = 3'h1;
  localparam logic [7:0] CNT_STEP = 8'h01;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  // fastest serial clock allowed to the master, in kHz; nothing in the port checks it
  localparam int SCK_MAX_KHZ = 125;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [ADR_W-1:0] adr;
    logic [31:0] dat;
  } wb_req_t;

  // one open-drain pin: level driven and active-low enable
  typedef struct packed {
    logic level;
    logic oeN;
  } od_pin_t;

  typedef enum logic [5:0] {
    ST_INIT = 6'h01,
    ST_IDLE = 6'h02,
    ST_CLAMP = 6'h04,
    ST_LOAD = 6'h08,
    ST_SHIFT = 6'h10,
    ST_DONE = 6'h20
  } link_state_t;

  typedef enum logic [2:0] {
    PH_CMD = 3'h1,
    PH_COUNT = 3'h2,
    PH_DATA = 3'h4
  } frame_phase_t;
endpackage

// File: tb/link_master_model.sv
// clock-master model of the far end: drives the clock line and data open-drain
`timescale 1ns/1ns
module link_master_model (
  // clock
  input wire logic clk,
  // wired line levels
  input wire logic sdaLine,
  output logic sckOut,
  output logic mosiOut
);
  // transfer-complete flag of the master's own port
  logic portDone = 1'b0;

  // 1 means released: both lines float high on their pull-ups
  initial begin
    sckOut = 1'b1;
    mosiOut = 1'b1;
  end

  task automatic takeControl();
    @(posedge clk);
    sckOut <= 1'b0;
  endtask

  // one handshaked byte; half period of 4 clk gives the 320 ns link clock
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    while (sdaLine !== 1'b1) @(posedge clk);
    @(posedge clk);
    sckOut <= 1'b1;
    while (sdaLine !== 1'b0) @(posedge clk);
    @(posedge clk);
    sckOut <= 1'b0;
    while (sdaLine !== 1'b1) @(posedge clk);
    for (int i = 7; i >= 0; i--) begin
      @(posedge clk);
      sckOut <= 1'b1;
      mosiOut <= tx[i];
      repeat (4) @(posedge clk);
      sckOut <= 1'b0;
      // slave holds its bit until the next rise, so sample just after the fall
      @(posedge clk);
      rx[i] = sdaLine;
      repeat (2) @(posedge clk);
    end
    portDone = 1'b1;
    @(posedge clk);
    mosiOut <= 1'b1;
    // the flag is cleared at once, with no status read or data access modelled
    if (portDone) begin
      portDone = 1'b0;
    end
  endtask
endmodule

// File: tb/handshaked_halfduplex_spi_link_test.sv
// self-checking bench for the link slave with a clock-master model
`timescale 1ns/1ns
module handshaked_halfduplex_spi_link_test;
  import link_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  wb_req_t wbReq = '0;
  logic wbAck;
  logic [31:0] wbDatOut;
  od_pin_t sdaPin;
  od_pin_t ssPin;
  logic sckOut;
  logic mosiOut;
  logic sdaLine;
  int failures = 0;
  int numChecks = 0;
  int cycles = 0;
  logic [31:0] rd;
  logic [7:0] rx;
  logic [31:0] wiredOrSet;

  assign wiredOrSet = 32'h1 << BIT_WOR;
  assign sdaLine = ~((~sdaPin.oeN & ~sdaPin.level) | ~mosiOut);

  link_slave i_dut (.clk(clk), .rst(rst), .wbReq(wbReq), .wbAck(wbAck), .wbDatOut(wbDatOut),
    .sckIn(sckOut), .sdaIn(sdaLine), .sdaPin(sdaPin), .ssPin(ssPin));
  link_master_model i_master (.clk(clk), .sdaLine(sdaLine), .sckOut(sckOut), .mosiOut(mosiOut));

  initial begin
    forever #20 clk = ~clk;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", numChecks, failures);
    if (failures == 0 && numChecks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      report_and_stop();
    end
  end

  task automatic wbXfer(input logic we, input logic [3:0] adr, input logic [31:0] dat,
                        output logic [31:0] data);
    @(posedge clk);
    wbReq <= {1'b1, 1'b1, we, 4'hf, adr, dat};
    do @(posedge clk); while (wbAck !== 1'b1);
    data = wbDatOut;
    wbReq <= '0;
  endtask

  // arm one byte, let the master clock it, then collect and clear the done flag
  task automatic doByte(input logic [7:0] slaveTx, input logic [7:0] mTx,
                        output logic [7:0] mRx);
    logic [31:0] d;
    wbXfer(1'b1, OFS_DATA, {24'h0, slaveTx}, d);
    wbXfer(1'b1, OFS_CTRL, wiredOrSet | (32'h1 << BIT_ARM), d);
    i_master.xfer(mTx, mRx);
    do wbXfer(1'b0, OFS_CTRL, 32'h0, d); while (d[BIT_DONE] !== 1'b1);
    check("done", {31'h0, d[BIT_DONE]}, 32'h1);
    check("sda idle", {31'h0, sdaLine}, 32'h1);
    wbXfer(1'b1, OFS_CTRL, wiredOrSet, d);
    wbXfer(1'b0, OFS_CTRL, 32'h0, d);
    check("done clr", {31'h0, d[BIT_DONE]}, 32'h0);
    check("wor bit", {31'h0, d[BIT_WOR]}, 32'h1);
    check("arm clr", {31'h0, d[BIT_ARM]}, 32'h0);
  endtask

  task automatic checkStat(input logic [2:0] ph, input logic talk, input logic [7:0] cnt);
    logic [31:0] d;
    wbXfer(1'b0, OFS_STAT, 32'h0, d);
    check("phase", {29'h0, d[PH_LSB+:3]}, {29'h0, ph});
    check("talk", {31'h0, d[BIT_TALK]}, {31'h0, talk});
    check("remain", {24'h0, d[CNT_LSB+:8]}, {24'h0, cnt});
    check("err", {31'h0, d[BIT_ERR]}, 32'h0);
  endtask

  task automatic testStartup();
    check("ss idle", {30'h0, ssPin}, 32'h3);
    check("sda rst", {30'h0, sdaPin}, 32'h3);
    repeat (10) @(posedge clk);
    check("ss wait", {30'h0, ssPin}, 32'h3);
    i_master.takeControl();
    repeat (8) @(posedge clk);
    check("ss out", {30'h0, ssPin}, 32'h2);
    wbXfer(1'b1, 4'hc, 32'h0000_00ff, rd);
    wbXfer(1'b0, 4'hc, 32'h0, rd);
    check("unmapped", rd, 32'h0);
    $display("test startup done");
  endtask

  task automatic testListen();
    doByte(8'h00, 8'h7e, rx);
    checkStat(PH_CMD, 1'b0, 8'h00);
    doByte(8'h00, CMD_LISTEN, rx);
    checkStat(PH_COUNT, 1'b0, 8'h00);
    doByte(8'h00, 8'h02, rx);
    checkStat(PH_DATA, 1'b0, 8'h02);
    doByte(8'h00, 8'ha5, rx);
    wbXfer(1'b0, OFS_DATA, 32'h0, rd);
    check("rx a5", rd, 32'h0000_00a5);
    doByte(8'h00, 8'h3c, rx);
    wbXfer(1'b0, OFS_DATA, 32'h0, rd);
    check("rx 3c", rd, 32'h0000_003c);
    checkStat(PH_CMD, 1'b0, 8'h00);
    $display("test listen done");
  endtask

  task automatic testTalk();
    doByte(8'h00, CMD_TALK, rx);
    checkStat(PH_COUNT, 1'b1, 8'h00);
    doByte(8'h01, BYTE_ONES, rx);
    check("tx count", {24'h0, rx}, 32'h0000_0001);
    doByte(8'h96, BYTE_ONES, rx);
    check("tx data", {24'h0, rx}, 32'h0000_0096);
    wbXfer(1'b0, OFS_DATA, 32'h0, rd);
    check("readback", rd, 32'h0000_0096);
    checkStat(PH_CMD, 1'b0, 8'h00);
    $display("test talk done");
  endtask

  // master pulls the line low while the slave sends its count: readback must flag it
  task automatic testContention();
    doByte(8'h00, CMD_TALK, rx);
    doByte(8'h01, 8'h00, rx);
    check("clash rx", {24'h0, rx}, 32'h0);
    wbXfer(1'b0, OFS_STAT, 32'h0, rd);
    check("err set", {31'h0, rd[BIT_ERR]}, 32'h1);
    check("clash phase", {29'h0, rd[PH_LSB+:3]}, {29'h0, PH_CMD});
    wbXfer(1'b1, OFS_STAT, 32'h0, rd);
    checkStat(PH_CMD, 1'b0, 8'h00);
    $display("test contention done");
  endtask

  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    testStartup();
    testListen();
    testTalk();
    testContention();
    report_and_stop();
  end
endmodule
